// file: rtl/ctsr_pkg.sv
/*
 * constants shared by the charger thermal/status register bank:
 * register offsets, field positions, reset values and lookup tables.
 * assumes an 8-bit register address space and 8-bit register data.
 */
package ctsr_pkg;
    timeunit 1ns;
    timeprecision 1ns;

    typedef logic [7:0]  ctsr_byte_t;
    typedef logic [15:0] ctsr_beta_t;

    // register offsets
    localparam ctsr_byte_t ADDR_THERMAL_CONFIG      = 8'h17;
    localparam ctsr_byte_t ADDR_HEALTH_STATUS       = 8'h18;
    localparam ctsr_byte_t ADDR_INPUT_THERMAL_STAT  = 8'h19;

    // register selector returned by the address decoder
    typedef enum logic [1:0] {
        SEL_NONE    = 2'b00,
        SEL_CONFIG  = 2'b01,
        SEL_HEALTH  = 2'b10,
        SEL_INPUT   = 2'b11
    } ctsr_sel_t;

    // thermal config fields
    localparam int BETA_SEL_MSB   = 7;
    localparam int BETA_SEL_LSB   = 5;
    localparam int THM_THR_MSB    = 2;
    localparam int THM_THR_LSB    = 0;
    localparam ctsr_byte_t CONFIG_RESET = 8'h24;  // beta 001, rsvd 00, threshold 100

    // health status bit positions
    localparam int HLT_ATTACHED_BIT = 7;
    localparam int HLT_BAT_OK_BIT   = 6;
    localparam int HLT_PWR_OK_BIT   = 5;
    localparam int HLT_CHARGER_HEALTHY_BIT   = 4;

    // input/thermal status bit positions
    localparam int INP_PWR_MSB      = 7;
    localparam int INP_PWR_LSB      = 6;
    localparam int INP_FOLDBACK_BIT = 4;

    localparam ctsr_byte_t BYTE_ZERO = 8'h00;

    // condition codes
    localparam logic [2:0] BAT_COND_MISSING  = 3'h0;
    localparam logic [2:0] BAT_COND_TOP_OK   = 3'h5;
    localparam logic [2:0] BAT_COND_IN_RESET = 3'h7;
    localparam logic [1:0] PWR_COND_VALID    = 2'h3;
    localparam logic [2:0] TEMP_CODE_COLD    = 3'h1;
    localparam logic [2:0] TEMP_CODE_HOT     = 3'h4;
    localparam logic [1:0] TIMER_NO_EFFECT   = 2'h0;

    // die regulation threshold: base plus step per code, in degrees C
    localparam ctsr_byte_t DIE_THR_BASE_C = 8'h50;
    localparam ctsr_byte_t DIE_THR_STEP_C = 8'h05;

    // thermistor beta values in kelvin, indexed by selection code
    localparam ctsr_beta_t BETA_TABLE [8] = '{
        16'h0d6a, 16'h0e1a, 16'h0f5e, 16'h0f6e,
        16'h1004, 16'h10d7, 16'h11bf, 16'h128e
    };
    localparam ctsr_beta_t BETA_RESET = 16'h0e1a;

    // synchroniser image of the condition inputs after reset:
    // {attached, condition[2:0], power[1:0], temp[2:0], timer[1:0], die[7:0]}
    localparam int COND_W = 19;
    localparam logic [18:0] COND_RESET = 19'h3_8000;

endpackage

// file: rtl/ctsr_cond_if.sv
/*
 * carries the synchronised analog condition levels from the input
 * synchroniser to the register bank.
 * assumes both ends share one clock.
 */
interface ctsr_cond_if;
    timeunit 1ns;
    timeprecision 1ns;
    logic       battery_attached;
    logic [2:0] battery_condition_code;
    logic [1:0] input_power_condition;
    logic [2:0] battery_temperature_code;
    logic [1:0] safety_timer_condition;
    logic [7:0] die_temp_c;

    modport sync_side (
        output battery_attached,
        output battery_condition_code,
        output input_power_condition,
        output battery_temperature_code,
        output safety_timer_condition,
        output die_temp_c
    );

    modport reg_side (
        input battery_attached,
        input battery_condition_code,
        input input_power_condition,
        input battery_temperature_code,
        input safety_timer_condition,
        input die_temp_c
    );
endinterface

// file: rtl/ctsr_cond_sync.sv
/*
 * two-flop synchroniser for the charger condition inputs.
 * assumes the inputs are slow levels from analog comparators; multi-bit
 * codes may show one mixed sample while changing, which the next cycle clears.
 */
module ctsr_cond_sync (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       battery_attached_in,
    input  wire logic [2:0] battery_condition_code_in,
    input  wire logic [1:0] input_power_condition_in,
    input  wire logic [2:0] battery_temperature_code_in,
    input  wire logic [1:0] safety_timer_condition_in,
    input  wire logic [7:0] die_temp_c_in,
    ctsr_cond_if.sync_side  cond
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [ctsr_pkg::COND_W-1:0] raw;
    logic [ctsr_pkg::COND_W-1:0] meta_q;
    logic [ctsr_pkg::COND_W-1:0] stable_q;

    assign raw = {battery_attached_in, battery_condition_code_in, input_power_condition_in,
                  battery_temperature_code_in, safety_timer_condition_in, die_temp_c_in};

    // meta_q feeds stable_q only
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            meta_q   <= ctsr_pkg::COND_RESET;
            stable_q <= ctsr_pkg::COND_RESET;
        end
        else
        begin
            meta_q   <= raw;
            stable_q <= meta_q;
        end
    end

    assign cond.battery_attached         = stable_q[18];
    assign cond.battery_condition_code   = stable_q[17:15];
    assign cond.input_power_condition    = stable_q[14:13];
    assign cond.battery_temperature_code = stable_q[12:10];
    assign cond.safety_timer_condition   = stable_q[9:8];
    assign cond.die_temp_c               = stable_q[7:0];
endmodule

// file: rtl/ctsr_regs.sv
/*
 * charger thermal configuration and status register bank: one read/write
 * configuration register and two read-only status registers.
 * assumes a simple synchronous register port driven by the host interface
 * logic, and condition levels from the analog charger.
 */
module ctsr_regs (
    input  wire logic        MCLK_IN,
    input  wire logic        SYS_RST_IN,
    input  wire logic [7:0]  REG_ADDR_IN,
    input  wire logic        REG_WR_EN_IN,
    input  wire logic [7:0]  REG_WDATA_IN,
    input  wire logic        REG_RD_EN_IN,
    output logic      [7:0]  REG_RDATA_OUT,
    input  wire logic        BATTERY_ATTACHED_IN,
    input  wire logic [2:0]  BATTERY_CONDITION_CODE_IN,
    input  wire logic [1:0]  INPUT_POWER_CONDITION_IN,
    input  wire logic [2:0]  BATTERY_TEMPERATURE_CODE_IN,
    input  wire logic [1:0]  SAFETY_TIMER_CONDITION_IN,
    input  wire logic [7:0]  DIE_TEMP_C_IN,
    output logic      [2:0]  THERMISTOR_BETA_SELECT_OUT,
    output logic      [15:0] THERMISTOR_BETA_K_OUT,
    output logic      [2:0]  DIE_TEMP_REGULATION_THRESHOLD_OUT,
    output logic      [7:0]  DIE_TEMP_THRESHOLD_C_OUT,
    output logic             THERMAL_FOLDBACK_ACTIVE_OUT
);

    timeunit 1ns;
    timeprecision 1ns;

    ctsr_pkg::ctsr_byte_t config_q;
    ctsr_pkg::ctsr_byte_t health_q;
    ctsr_pkg::ctsr_byte_t health_d;
    ctsr_pkg::ctsr_byte_t input_q;
    ctsr_pkg::ctsr_byte_t input_d;
    ctsr_pkg::ctsr_byte_t rdata_d;
    ctsr_pkg::ctsr_byte_t thr_c;
    logic [2:0]           beta_sel;
    logic [2:0]           thr_code;
    logic                 foldback;

    // forwarded settings start from the config register's own reset image
    localparam logic [2:0] BETA_SEL_RESET =
        ctsr_pkg::CONFIG_RESET[ctsr_pkg::BETA_SEL_MSB:ctsr_pkg::BETA_SEL_LSB];
    localparam logic [2:0] THR_CODE_RESET =
        ctsr_pkg::CONFIG_RESET[ctsr_pkg::THM_THR_MSB:ctsr_pkg::THM_THR_LSB];
    localparam ctsr_pkg::ctsr_byte_t THR_C_RESET =
        8'(ctsr_pkg::DIE_THR_BASE_C + ctsr_pkg::DIE_THR_STEP_C * {5'h00, THR_CODE_RESET});

    ctsr_cond_if cond ();

    ctsr_cond_sync i_ctsr_cond_sync (
        .clk_in                      (MCLK_IN),
        .rst_in                      (SYS_RST_IN),
        .battery_attached_in         (BATTERY_ATTACHED_IN),
        .battery_condition_code_in   (BATTERY_CONDITION_CODE_IN),
        .input_power_condition_in    (INPUT_POWER_CONDITION_IN),
        .battery_temperature_code_in (BATTERY_TEMPERATURE_CODE_IN),
        .safety_timer_condition_in   (SAFETY_TIMER_CONDITION_IN),
        .die_temp_c_in               (DIE_TEMP_C_IN),
        .cond                        (cond.sync_side)
    );

    // shared by the write path and the read path
    function automatic ctsr_pkg::ctsr_sel_t decode_addr(input ctsr_pkg::ctsr_byte_t addr);
        ctsr_pkg::ctsr_sel_t sel;
        sel = ctsr_pkg::SEL_NONE;
        if (addr == ctsr_pkg::ADDR_THERMAL_CONFIG)
            sel = ctsr_pkg::SEL_CONFIG;
        else if (addr == ctsr_pkg::ADDR_HEALTH_STATUS)
            sel = ctsr_pkg::SEL_HEALTH;
        else if (addr == ctsr_pkg::ADDR_INPUT_THERMAL_STAT)
            sel = ctsr_pkg::SEL_INPUT;
        return sel;
    endfunction

    // threshold in degrees C for a threshold code
    function automatic ctsr_pkg::ctsr_byte_t thr_to_c(input logic [2:0] code);
        logic [7:0] prod;
        prod = 8'(ctsr_pkg::DIE_THR_STEP_C * {5'h00, code});
        return 8'(ctsr_pkg::DIE_THR_BASE_C + prod);
    endfunction

    assign beta_sel = config_q[ctsr_pkg::BETA_SEL_MSB:ctsr_pkg::BETA_SEL_LSB];
    assign thr_code = config_q[ctsr_pkg::THM_THR_MSB:ctsr_pkg::THM_THR_LSB];
    assign thr_c    = thr_to_c(thr_code);
    // strictly greater: at the threshold itself full current is kept
    assign foldback = (cond.die_temp_c > thr_c);

    // configuration register: every bit, reserved ones included, is stored
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            config_q <= ctsr_pkg::CONFIG_RESET;
        else if (REG_WR_EN_IN && decode_addr(REG_ADDR_IN) == ctsr_pkg::SEL_CONFIG)
            config_q <= REG_WDATA_IN;
    end

    // status images, rebuilt every cycle; reserved bits stay zero
    always_comb
    begin
        health_d = ctsr_pkg::BYTE_ZERO;
        input_d  = ctsr_pkg::BYTE_ZERO;
        health_d[ctsr_pkg::HLT_ATTACHED_BIT] = cond.battery_attached;
        // code 110 is reserved and is not reported as a good battery
        health_d[ctsr_pkg::HLT_BAT_OK_BIT] =
            (cond.battery_condition_code != ctsr_pkg::BAT_COND_MISSING) &&
            (cond.battery_condition_code <= ctsr_pkg::BAT_COND_TOP_OK);
        health_d[ctsr_pkg::HLT_PWR_OK_BIT] =
            (cond.input_power_condition == ctsr_pkg::PWR_COND_VALID);
        health_d[ctsr_pkg::HLT_CHARGER_HEALTHY_BIT] =
            (cond.battery_temperature_code != ctsr_pkg::TEMP_CODE_COLD) &&
            (cond.battery_temperature_code != ctsr_pkg::TEMP_CODE_HOT) &&
            (cond.safety_timer_condition == ctsr_pkg::TIMER_NO_EFFECT);
        input_d[ctsr_pkg::INP_PWR_MSB:ctsr_pkg::INP_PWR_LSB] =
            cond.input_power_condition;
        input_d[ctsr_pkg::INP_FOLDBACK_BIT] = foldback;
    end

    // no write path reaches these: host writes to them fall away
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            health_q <= ctsr_pkg::BYTE_ZERO | (8'h01 << ctsr_pkg::HLT_CHARGER_HEALTHY_BIT);
            input_q  <= ctsr_pkg::BYTE_ZERO;
        end
        else
        begin
            health_q <= health_d;
            input_q  <= input_d;
        end
    end

    always_comb
    begin
        unique case (decode_addr(REG_ADDR_IN))
            ctsr_pkg::SEL_CONFIG: rdata_d = config_q;
            ctsr_pkg::SEL_HEALTH: rdata_d = health_q;
            ctsr_pkg::SEL_INPUT:  rdata_d = input_q;
            ctsr_pkg::SEL_NONE:   rdata_d = ctsr_pkg::BYTE_ZERO;
        endcase
    end

    // read data holds until the next read strobe
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            REG_RDATA_OUT <= ctsr_pkg::BYTE_ZERO;
        else if (REG_RD_EN_IN)
            REG_RDATA_OUT <= rdata_d;
    end

    // settings forwarded to the temperature sensing and regulation loop
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            THERMISTOR_BETA_SELECT_OUT        <= BETA_SEL_RESET;
            THERMISTOR_BETA_K_OUT             <= ctsr_pkg::BETA_RESET;
            DIE_TEMP_REGULATION_THRESHOLD_OUT <= THR_CODE_RESET;
            DIE_TEMP_THRESHOLD_C_OUT          <= THR_C_RESET;
            THERMAL_FOLDBACK_ACTIVE_OUT       <= 1'b0;
        end
        else
        begin
            THERMISTOR_BETA_SELECT_OUT        <= beta_sel;
            THERMISTOR_BETA_K_OUT             <= ctsr_pkg::BETA_TABLE[beta_sel];
            DIE_TEMP_REGULATION_THRESHOLD_OUT <= thr_code;
            DIE_TEMP_THRESHOLD_C_OUT          <= thr_c;
            THERMAL_FOLDBACK_ACTIVE_OUT       <= foldback;
        end
    end

endmodule

// file: sim/ctsr_regs_asserts.sv
/* port assertions for ctsr_regs.
   assumes one clock and an active-high asynchronous reset. */
module ctsr_regs_asserts (
    input wire logic        MCLK_IN,
    input wire logic        SYS_RST_IN,
    input wire logic [7:0]  REG_ADDR_IN,
    input wire logic        REG_WR_EN_IN,
    input wire logic [7:0]  REG_WDATA_IN,
    input wire logic        REG_RD_EN_IN,
    input wire logic [7:0]  REG_RDATA_OUT,
    input wire logic        BATTERY_ATTACHED_IN,
    input wire logic [2:0]  BATTERY_CONDITION_CODE_IN,
    input wire logic [1:0]  INPUT_POWER_CONDITION_IN,
    input wire logic [2:0]  BATTERY_TEMPERATURE_CODE_IN,
    input wire logic [1:0]  SAFETY_TIMER_CONDITION_IN,
    input wire logic [7:0]  DIE_TEMP_C_IN,
    input wire logic [2:0]  THERMISTOR_BETA_SELECT_OUT,
    input wire logic [15:0] THERMISTOR_BETA_K_OUT,
    input wire logic [2:0]  DIE_TEMP_REGULATION_THRESHOLD_OUT,
    input wire logic [7:0]  DIE_TEMP_THRESHOLD_C_OUT,
    input wire logic        THERMAL_FOLDBACK_ACTIVE_OUT
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] BETA_K [8] = '{16'h0d6a, 16'h0e1a, 16'h0f5e, 16'h0f6e,
                                          16'h1004, 16'h10d7, 16'h11bf, 16'h128e};
    wire logic        cfg_wr = REG_WR_EN_IN && REG_ADDR_IN == 8'h17;
    wire logic [2:0]  wd_beta = REG_WDATA_IN[7:5];
    wire logic [2:0]  wd_thr = REG_WDATA_IN[2:0];
    wire logic [10:0] cond = {BATTERY_ATTACHED_IN, BATTERY_CONDITION_CODE_IN,
        INPUT_POWER_CONDITION_IN, BATTERY_TEMPERATURE_CODE_IN, SAFETY_TIMER_CONDITION_IN};
    wire logic [7:0]  stat0 = {BATTERY_ATTACHED_IN, BATTERY_CONDITION_CODE_IN inside {[3'h1:3'h5]},
        INPUT_POWER_CONDITION_IN == 2'h3, !(BATTERY_TEMPERATURE_CODE_IN == 3'h1 ||
        BATTERY_TEMPERATURE_CODE_IN == 3'h4 || SAFETY_TIMER_CONDITION_IN != 2'h0), 4'h0};

    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (SYS_RST_IN);

    // five quiet samples cover the synchroniser plus the status flop
    sequence s_cond_held;
        $stable(cond)[*5];
    endsequence
    sequence s_cfg_wr;
        cfg_wr ##1 (!cfg_wr)[*2];
    endsequence

    property p_beta_map;
        THERMISTOR_BETA_K_OUT == BETA_K[THERMISTOR_BETA_SELECT_OUT];
    endproperty
    a_beta_map: assert property (p_beta_map) else $error("beta value off");
    property p_thr_map;
        DIE_TEMP_THRESHOLD_C_OUT == 8'h50 + 8'h05 * DIE_TEMP_REGULATION_THRESHOLD_OUT;
    endproperty
    a_thr_map: assert property (p_thr_map) else $error("threshold degrees off");
    property p_cfg_out;
        s_cfg_wr |=> THERMISTOR_BETA_SELECT_OUT == $past(wd_beta, 3)
            && DIE_TEMP_REGULATION_THRESHOLD_OUT == $past(wd_thr, 3);
    endproperty
    a_cfg_out: assert property (p_cfg_out) else $error("config fields stale");
    // window of six lets a threshold change settle on either side
    property p_fold_hi;
        (DIE_TEMP_C_IN > DIE_TEMP_THRESHOLD_C_OUT)[*6] |-> THERMAL_FOLDBACK_ACTIVE_OUT;
    endproperty
    a_fold_hi: assert property (p_fold_hi) else $error("foldback missing");
    property p_fold_lo;
        (DIE_TEMP_C_IN <= DIE_TEMP_THRESHOLD_C_OUT)[*6] |-> !THERMAL_FOLDBACK_ACTIVE_OUT;
    endproperty
    a_fold_lo: assert property (p_fold_lo) else $error("foldback spurious");
    property p_stat0;
        s_cond_held ##0 (REG_RD_EN_IN && REG_ADDR_IN == 8'h18) |=> REG_RDATA_OUT == $past(stat0);
    endproperty
    a_stat0: assert property (p_stat0) else $error("health status off");
    property p_stat1;
        s_cond_held ##0 (REG_RD_EN_IN && REG_ADDR_IN == 8'h19)
            |=> {REG_RDATA_OUT[7:5], REG_RDATA_OUT[3:0]} == {$past(cond[6:5]), 5'h00};
    endproperty
    a_stat1: assert property (p_stat1) else $error("input status off");
    property p_rd_unmapped;
        REG_RD_EN_IN && !(REG_ADDR_IN inside {[8'h17:8'h19]}) |=> REG_RDATA_OUT == 8'h00;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read nonzero");
    property p_rd_hold;
        !REG_RD_EN_IN |=> $stable(REG_RDATA_OUT);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule

bind ctsr_regs ctsr_regs_asserts i_ctsr_regs_asserts (.MCLK_IN(MCLK_IN), .SYS_RST_IN(SYS_RST_IN),
    .REG_ADDR_IN(REG_ADDR_IN), .REG_WR_EN_IN(REG_WR_EN_IN), .REG_WDATA_IN(REG_WDATA_IN),
    .REG_RD_EN_IN(REG_RD_EN_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
    .BATTERY_ATTACHED_IN(BATTERY_ATTACHED_IN),
    .BATTERY_CONDITION_CODE_IN(BATTERY_CONDITION_CODE_IN),
    .INPUT_POWER_CONDITION_IN(INPUT_POWER_CONDITION_IN), .DIE_TEMP_C_IN(DIE_TEMP_C_IN),
    .BATTERY_TEMPERATURE_CODE_IN(BATTERY_TEMPERATURE_CODE_IN),
    .SAFETY_TIMER_CONDITION_IN(SAFETY_TIMER_CONDITION_IN),
    .THERMISTOR_BETA_SELECT_OUT(THERMISTOR_BETA_SELECT_OUT),
    .THERMISTOR_BETA_K_OUT(THERMISTOR_BETA_K_OUT),
    .DIE_TEMP_REGULATION_THRESHOLD_OUT(DIE_TEMP_REGULATION_THRESHOLD_OUT),
    .DIE_TEMP_THRESHOLD_C_OUT(DIE_TEMP_THRESHOLD_C_OUT),
    .THERMAL_FOLDBACK_ACTIVE_OUT(THERMAL_FOLDBACK_ACTIVE_OUT));

// file: sim/ctsr_regs_bench.sv
/* self-checking bench for ctsr_regs.
   drives the register port and condition levels itself; no partner model. */
module ctsr_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk, rst, wr_en, rd_en, att, fold;
    logic [7:0]  addr, wdata, rdata, die, thr_c;
    logic [2:0]  code, temp, bsel, thr;
    logic [1:0]  pwr, timer;
    logic [15:0] beta_k;
    int          n_mismatch = 0;
    int          n_checks = 0;
    localparam logic [15:0] BETA_K [8] = '{16'h0d6a, 16'h0e1a, 16'h0f5e, 16'h0f6e,
                                          16'h1004, 16'h10d7, 16'h11bf, 16'h128e};

    ctsr_regs i_ctsr_regs (.MCLK_IN(mclk), .SYS_RST_IN(rst), .REG_ADDR_IN(addr),
        .REG_WR_EN_IN(wr_en), .REG_WDATA_IN(wdata), .REG_RD_EN_IN(rd_en), .REG_RDATA_OUT(rdata),
        .BATTERY_ATTACHED_IN(att), .BATTERY_CONDITION_CODE_IN(code),
        .INPUT_POWER_CONDITION_IN(pwr), .BATTERY_TEMPERATURE_CODE_IN(temp),
        .SAFETY_TIMER_CONDITION_IN(timer), .DIE_TEMP_C_IN(die),
        .THERMISTOR_BETA_SELECT_OUT(bsel), .THERMISTOR_BETA_K_OUT(beta_k),
        .DIE_TEMP_REGULATION_THRESHOLD_OUT(thr), .DIE_TEMP_THRESHOLD_C_OUT(thr_c),
        .THERMAL_FOLDBACK_ACTIVE_OUT(fold));

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // strobes are left as set so no signal is written twice in one step
    task automatic cyc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        wr_en = w;
        rd_en = r;
        addr = a;
        wdata = d;
        @(posedge mclk);
        #1;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        cyc(1'b0, 1'b1, a, 8'h00);
        chk(16'(rdata), 16'(exp));
    endtask

    task automatic setc(input logic [10:0] c, input logic [7:0] d);
        {att, code, pwr, temp, timer} = c;
        die = d;
        repeat (6) cyc(1'b0, 1'b0, 8'h00, 8'h00);
    endtask

    function automatic logic [7:0] exp0(input logic [10:0] c);
        return {c[10], c[9:7] inside {[3'h1:3'h5]}, c[6:5] == 2'h3,
                !(c[4:2] == 3'h1 || c[4:2] == 3'h4 || c[1:0] != 2'h0), 4'h0};
    endfunction

    task automatic final_report;
        $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        logic [10:0] c;
        logic [7:0]  v;
        rst = 1'b1;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        die = 8'h00;
        {att, code, pwr, temp, timer} = 11'h380;
        repeat (3) @(posedge mclk);
        #1;
        rst = 1'b0;
        chk(16'(bsel), 16'h0001);
        chk(beta_k, 16'h0e1a);
        chk(16'(thr_c), 16'h0064);
        rdc(8'h17, 8'h24);
        rdc(8'h18, 8'h10);
        rdc(8'h19, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            v = {i[2:0], i[1:0], i[2:0]};
            cyc(1'b1, 1'b0, 8'h17, v);
            rdc(8'h17, v);
            repeat (2) cyc(1'b0, 1'b0, 8'h00, 8'h00);
            chk(16'(bsel), 16'(i));
            chk(beta_k, BETA_K[i]);
            chk(16'(thr), 16'(i));
            chk(16'(thr_c), 16'(16'h0050 + 16'h0005 * i));
        end
        cyc(1'b1, 1'b1, 8'h17, 8'h5a);
        chk(16'(rdata), 16'h00ff);
        rdc(8'h17, 8'h5a);
        cyc(1'b1, 1'b0, 8'h17, 8'h24);
        cyc(1'b1, 1'b0, 8'h18, 8'hff);
        cyc(1'b1, 1'b0, 8'h19, 8'hff);
        cyc(1'b1, 1'b0, 8'h1a, 8'hff);
        rdc(8'h18, 8'h10);
        rdc(8'h19, 8'h00);
        rdc(8'h1a, 8'h00);
        rdc(8'h17, 8'h24);
        for (int i = 0; i < 8; i++)
        begin
            c = {i[0], i[2:0], i[1:0], 3'(i % 5), i[2] & i[0], i[2] & i[1]};
            setc(c, 8'h00);
            rdc(8'h18, exp0(c));
            rdc(8'h19, {c[6:5], 6'h00});
        end
        for (int j = 0; j < 4; j++)
        begin
            v = j[1] ? 8'h07 : 8'h04;
            cyc(1'b1, 1'b0, 8'h17, v);
            setc(11'h060, 8'(8'h50 + 8'h05 * v + 8'(j[0])));
            chk(16'(fold), 16'(j[0]));
            rdc(8'h19, {3'h6, j[0], 4'h0});
        end
        final_report;
    end

    // the sequence needs about 150 cycles; 5000 leaves ample margin
    initial
    begin
        #50000;
        n_mismatch++;
        final_report;
    end
endmodule
